// File: verilog/ser_status_event_reporting.sv
// Purpose: standard event, quality event, status byte and error queue
// Assumes: commands arrive one per cmdValid pulse in execution order
// Notes: answers on respValid one cycle after the command
`timescale 1ns/1ns
`default_nettype none
`include "ser_defs.svh"
////////////////////////////////////////////////////////////////////////
// Contract
// - opcDone after an opc command sets standard bit 0 when all prior commands have finished.
// - query error events set standard bit 2.
// - self-test, calibration or overload failure sets standard bit 3.
// - execution failure sets standard bit 4.
// - command syntax error sets standard bit 5.
// - power-on sets standard bit 7 until read or cleared.
// - clear-status or event status query clears standard register.
// - power-on-clear flag chooses whether both masks clear at power-up.
// - standard enable mask loaded by write; enabled bits feed summary.
// - overload sets standard bit 3 and quality bit, no queue entry.
// - voltage-type range overload sets quality bit 0.
// - current range overload sets quality bit 1.
// - resistance range overload sets quality bit 9.
// - reading below lower limit sets quality bit 11.
// - reading above upper limit sets quality bit 12.
// - clear-status or quality event query clears quality register.
// - quality enable mask loaded by write; enabled bits feed summary.
// - quality mask cleared at power-up, on preset, on zero write.
// - twenty-entry error queue, eighty characters, returned oldest first.
// - queries return binary-weighted value; mask queries change nothing.
// - clear-status clears summary register and every event register.
// - operation-complete query answers value one after execution.
// - status byte mask loaded by write and read back unchanged.
// - status byte query in order, rqs not cleared by it.
// - quality summary at status bit 3, standard summary at bit 5.
// - enabled summary sets bit 6 and service request; poll clears bit 6.
module ser_status_event_reporting
  import ser_pkg::*;
#(
  parameter int ERR_DEPTH = `SER_ERR_DEPTH,
  parameter int ERR_CHARS = `SER_ERR_CHARS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input wire ser_cmd_type cmdCode,
  input wire logic [15:0] cmdValue,
  input wire logic opcDone,
  input wire logic queryError,
  input wire logic selfTestFail,
  input wire logic calFail,
  input wire logic execError,
  input wire logic syntaxError,
  input wire logic overloadVolt,
  input wire logic overloadCurr,
  input wire logic overloadOhms,
  input wire logic limit_below_lower,
  input wire logic limit_above_upper,
  input wire logic messageAvailable,
  input wire logic serialPoll,
  input wire logic nvPowerOnClear,
  input wire logic errPush,
  input wire logic [8*ERR_CHARS-1:0] errPushText,
  input wire logic errPop,
  output logic [15:0] respValue,
  output logic respValid,
  output logic [7:0] pollByte,
  output logic pollValid,
  output logic serviceRequest,
  output logic powerOnClear,
  output logic [8*ERR_CHARS-1:0] errText,
  output logic errValid,
  output logic errEmpty,
  output logic errFull
);
  ////////////////////////////////////////////////////////////////////////
  localparam int PTR_W = $clog2(ERR_DEPTH);
  localparam logic [PTR_W:0] DEPTH_N = (PTR_W+1)'(ERR_DEPTH);
  localparam logic [PTR_W-1:0] LAST_IDX = PTR_W'(ERR_DEPTH - 1);

  logic [7:0] standard_event_latch;
  logic [15:0] measurement_quality_latch;
  logic [7:0] stdEnable;
  logic [15:0] qualEnable;
  logic [7:0] srqEnable;
  logic rqs;
  logic powerUp;
  logic [8*ERR_CHARS-1:0] errMem [ERR_DEPTH];
  logic [PTR_W-1:0] rdPtr;
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W:0] errCount;

  function automatic logic isCmd(input logic v, input ser_cmd_type c, input ser_cmd_type want);
    isCmd = v && (c == want);
  endfunction : isCmd

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == LAST_IDX) ? '0 : p + 1'b1;
  endfunction : bump

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire doCls = isCmd(cmdValid, cmdCode, SER_CMD_CLS);
  wire doEse = isCmd(cmdValid, cmdCode, SER_CMD_ESE);
  wire doEsrq = isCmd(cmdValid, cmdCode, SER_CMD_ESRQ);
  wire doOpc = isCmd(cmdValid, cmdCode, SER_CMD_OPC);
  wire doPsc = isCmd(cmdValid, cmdCode, SER_CMD_PSC);
  wire doSre = isCmd(cmdValid, cmdCode, SER_CMD_SRE);
  wire doQena = isCmd(cmdValid, cmdCode, SER_CMD_QENA);
  wire doQevtq = isCmd(cmdValid, cmdCode, SER_CMD_QEVTQ);
  wire doPreset = isCmd(cmdValid, cmdCode, SER_CMD_PRESET);
  wire isQuery = cmdValid && (cmdCode inside {SER_CMD_ESEQ, SER_CMD_ESRQ, SER_CMD_OPCQ, SER_CMD_PSCQ,
                                             SER_CMD_SREQ, SER_CMD_STBQ, SER_CMD_QENAQ, SER_CMD_QEVTQ});

  // opc only counts once its own command has executed; opcDone marks that
  wire opcArmed;
  logic opcPending;
  assign opcArmed = opcPending && opcDone;

  wire anyOverload = overloadVolt || overloadCurr || overloadOhms;
  wire [7:0] stdSet;
  assign stdSet[`SER_STD_OPC] = opcArmed;
  assign stdSet[1] = 1'b0;
  assign stdSet[`SER_STD_QRY] = queryError;
  assign stdSet[`SER_STD_DEV] = selfTestFail || calFail || anyOverload;
  assign stdSet[`SER_STD_EXE] = execError;
  assign stdSet[`SER_STD_CMD] = syntaxError;
  assign stdSet[6] = 1'b0;
  assign stdSet[`SER_STD_PON] = powerUp;

  // unused positions tied low here; the used-bit mask below is a second guard
  wire [15:0] qualSet;
  assign qualSet[`SER_QUAL_VOLT] = overloadVolt;
  assign qualSet[`SER_QUAL_CURR] = overloadCurr;
  assign qualSet[8:2] = 7'h00;
  assign qualSet[`SER_QUAL_OHMS] = overloadOhms;
  assign qualSet[10] = 1'b0;
  assign qualSet[`SER_QUAL_LO] = limit_below_lower;
  assign qualSet[`SER_QUAL_HI] = limit_above_upper;
  assign qualSet[15:13] = 3'b000;

  // set wins over clear so an event in the clearing cycle survives
  wire stdClr = doCls || doEsrq;
  wire qualClr = doCls || doQevtq;
  wire [7:0] next_std = ((stdClr ? 8'h00 : standard_event_latch) | stdSet) & `SER_STD_USED;
  wire [15:0] next_qual = ((qualClr ? 16'h0000 : measurement_quality_latch) | qualSet) & `SER_QUAL_USED;

  // summaries from current latch contents
  wire stdSummary = |(standard_event_latch & stdEnable);
  wire qualSummary = |(measurement_quality_latch & qualEnable);
  wire [7:0] statusBits;
  assign statusBits = {1'b0, rqs, stdSummary, messageAvailable, qualSummary, 3'b000};
  wire srqCause = |({2'b00, stdSummary, messageAvailable, qualSummary, 3'b000} & srqEnable & `SER_STB_USED);
  // rqs sets on a rise of cause; a poll or loss of cause clears it unless a new rise comes in that cycle
  logic srqCauseDly;
  wire srqRise = srqCause && !srqCauseDly;
  wire next_rqs = srqRise ? 1'b1 : (serialPoll || !srqCause) ? 1'b0 : rqs;

  // error queue
  wire errDoPush = errPush && (errCount != DEPTH_N);
  wire errDoPop = errPop && (errCount != '0);

  ////////////////////////////////////////////////////////////////////////
  // response mux
  logic [15:0] next_resp;
  always_comb begin
    next_resp = 16'h0000;
    case (cmdCode)
      SER_CMD_ESEQ: next_resp = {8'h00, stdEnable};
      SER_CMD_ESRQ: next_resp = {8'h00, standard_event_latch};
      SER_CMD_OPCQ: next_resp = 16'h0001;
      SER_CMD_PSCQ: next_resp = {15'h0000, powerOnClear};
      SER_CMD_SREQ: next_resp = {8'h00, srqEnable};
      SER_CMD_STBQ: next_resp = {8'h00, statusBits};
      SER_CMD_QENAQ: next_resp = qualEnable;
      SER_CMD_QEVTQ: next_resp = measurement_quality_latch;
      default: next_resp = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // powerUp marks the first cycle out of reset so std bit 7 records it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      powerUp <= 1'b1;
    end else begin
      powerUp <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      standard_event_latch <= 8'h00;
    end else begin
      standard_event_latch <= next_std;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      measurement_quality_latch <= 16'h0000;
    end else begin
      measurement_quality_latch <= next_qual;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      srqCauseDly <= 1'b0;
    end else begin
      srqCauseDly <= doCls ? 1'b0 : srqCause;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rqs <= 1'b0;
    end else begin
      rqs <= doCls ? 1'b0 : next_rqs;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      opcPending <= 1'b0;
    end else begin
      opcPending <= doOpc ? 1'b1 : (opcDone ? 1'b0 : opcPending);
    end
  end

  // value holds between queries so a slow reader still finds the answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      respValue <= 16'h0000;
    end else begin
      respValue <= isQuery ? next_resp : respValue;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      respValid <= 1'b0;
    end else begin
      respValid <= isQuery;
    end
  end

  // captured before rqs drops, since the poll must still report it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pollByte <= 8'h00;
    end else begin
      pollByte <= serialPoll ? statusBits : pollByte;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pollValid <= 1'b0;
    end else begin
      pollValid <= serialPoll;
    end
  end

  // mirrors the next rqs so pin and status bit change together
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serviceRequest <= 1'b0;
    end else begin
      serviceRequest <= next_rqs && !doCls;
    end
  end

  // nonvolatile flag: reset clears it; strapped value taken one cycle after release
  logic pscLoaded;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pscLoaded <= 1'b0;
      powerOnClear <= 1'b0;
    end else begin
      pscLoaded <= 1'b1;
      if (!pscLoaded) begin
        powerOnClear <= nvPowerOnClear;
      end else if (doPsc) begin
        powerOnClear <= cmdValue[0];
      end
    end
  end

  // masks hold through power-up unless the flag says clear
  always_ff @(posedge clk) begin
    if (pscLoaded == 1'b0 && !sys_rst && nvPowerOnClear) begin
      stdEnable <= 8'h00;
      srqEnable <= 8'h00;
    end else if (doEse) begin
      stdEnable <= cmdValue[7:0];
    end else if (doSre) begin
      srqEnable <= cmdValue[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || doPreset) begin
      qualEnable <= 16'h0000;
    end else if (doQena) begin
      qualEnable <= cmdValue;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (errDoPush) begin
      errMem[wrPtr] <= errPushText;
    end
  end

  // one shared next count keeps empty and full from disagreeing
  wire [PTR_W:0] errCountNext = errCount + (PTR_W+1)'(errDoPush) - (PTR_W+1)'(errDoPop);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr <= '0;
    end else begin
      wrPtr <= errDoPush ? bump(wrPtr) : wrPtr;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdPtr <= '0;
    end else begin
      rdPtr <= errDoPop ? bump(rdPtr) : rdPtr;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      errCount <= '0;
    end else begin
      errCount <= errCountNext;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      errText <= '0;
    end else begin
      errText <= errDoPop ? errMem[rdPtr] : errText;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      errValid <= 1'b0;
    end else begin
      errValid <= errDoPop;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      errEmpty <= 1'b1;
    end else begin
      errEmpty <= errCountNext == '0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      errFull <= 1'b0;
    end else begin
      errFull <= errCountNext == DEPTH_N;
    end
  end
endmodule : ser_status_event_reporting
`default_nettype wire

// File: verilog/ser_defs.svh
// Purpose: constants for status event reporting
// Assumes: one clock, synchronous reset
// Notes: bit positions, used-bit masks and error queue sizes
`ifndef SER_DEFS_SVH
`define SER_DEFS_SVH
`define SER_STD_OPC 0
`define SER_STD_QRY 2
`define SER_STD_DEV 3
`define SER_STD_EXE 4
`define SER_STD_CMD 5
`define SER_STD_PON 7
`define SER_STD_USED 8'hBD
`define SER_QUAL_VOLT 0
`define SER_QUAL_CURR 1
`define SER_QUAL_OHMS 9
`define SER_QUAL_LO 11
`define SER_QUAL_HI 12
`define SER_QUAL_USED 16'h1A03
`define SER_STB_QUAL 3
`define SER_STB_MAV 4
`define SER_STB_STD 5
`define SER_STB_RQS 6
`define SER_STB_USED 8'h38
`define SER_ERR_DEPTH 20
`define SER_ERR_CHARS 80
`endif

// File: verilog/ser_pkg.sv
// Purpose: shared types for status event reporting
// Assumes: nothing
// Notes: command codes presented on cmdCode
package ser_pkg;
  typedef enum logic [3:0] {
    SER_CMD_NONE = 4'h0,
    SER_CMD_CLS = 4'h1,
    SER_CMD_ESE = 4'h2,
    SER_CMD_ESEQ = 4'h3,
    SER_CMD_ESRQ = 4'h4,
    SER_CMD_OPC = 4'h5,
    SER_CMD_OPCQ = 4'h6,
    SER_CMD_PSC = 4'h7,
    SER_CMD_PSCQ = 4'h8,
    SER_CMD_SRE = 4'h9,
    SER_CMD_SREQ = 4'hA,
    SER_CMD_STBQ = 4'hB,
    SER_CMD_QENA = 4'hC,
    SER_CMD_QENAQ = 4'hD,
    SER_CMD_QEVTQ = 4'hE,
    SER_CMD_PRESET = 4'hF
  } ser_cmd_type;
endpackage : ser_pkg

// File: sim/ser_chk.sv
// Purpose: port checks for status event reporting
// Assumes: ser_pkg compiled first
// Notes: bound onto the top module below
`timescale 1ns/1ns
`default_nettype none
module ser_chk
  import ser_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input wire ser_cmd_type cmdCode,
  input wire logic serialPoll,
  input wire logic errPop,
  input wire logic [15:0] respValue,
  input wire logic respValid,
  input wire logic pollValid,
  input wire logic serviceRequest,
  input wire logic powerOnClear,
  input wire logic errValid,
  input wire logic errEmpty
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic isQuery = cmdValid && (cmdCode inside {SER_CMD_ESEQ, SER_CMD_ESRQ, SER_CMD_OPCQ,
    SER_CMD_PSCQ, SER_CMD_SREQ, SER_CMD_STBQ, SER_CMD_QENAQ, SER_CMD_QEVTQ});
  ////////////////////////////////////////////////////////////////////////
  a_query_answer: assert property (isQuery |=> respValid)
    else $error("query without answer");
  a_no_stray: assert property (!isQuery |=> !respValid)
    else $error("answer without query");
  a_opc_one: assert property (cmdValid && cmdCode == SER_CMD_OPCQ |=> respValue == 16'h0001)
    else $error("opc query not one");
  a_psc_value: assert property (cmdValid && cmdCode == SER_CMD_PSCQ |=> respValue == {15'h0000, powerOnClear})
    else $error("psc query wrong");
  a_std_unused: assert property (cmdValid && cmdCode == SER_CMD_ESRQ |=> (respValue & 16'hFF42) == 16'h0000)
    else $error("unused std bit set");
  a_qual_unused: assert property (cmdValid && cmdCode == SER_CMD_QEVTQ |=> (respValue & 16'hE5FC) == 16'h0000)
    else $error("unused quality bit set");
  a_poll_clears: assert property (serialPoll |=> pollValid && !serviceRequest)
    else $error("poll did not clear request");
  a_err_pop: assert property (errPop && !errEmpty |=> errValid)
    else $error("pop gave no entry");
endmodule : ser_chk
bind ser_status_event_reporting ser_chk chk_u (.clk, .sys_rst, .cmdValid, .cmdCode, .serialPoll, .errPop,
  .respValue, .respValid, .pollValid, .serviceRequest, .powerOnClear, .errValid, .errEmpty);
`default_nettype wire

// File: sim/ser_ctrl_model.sv
// Purpose: remote bus controller issuing status commands
// Assumes: tasks entered 1 ns after a rising edge
// Notes: value lines show garbage while idle
`timescale 1ns/1ns
`default_nettype none
module ser_ctrl_model
  import ser_pkg::*;
(
  input wire logic clk,
  output var logic cmdValid = 1'b0,
  output var ser_cmd_type cmdCode = SER_CMD_NONE,
  output var logic [15:0] cmdValue = 16'h0000,
  output var logic serialPoll = 1'b0
);
  task automatic send(input ser_cmd_type code, input logic [15:0] val);
    cmdValid = 1'b1;
    cmdCode = code;
    cmdValue = val;
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    // inverted so a stale value is never mistaken for a command
    cmdValue = ~val;
    // one idle edge so back-to-back commands never reassign in one step
    @(posedge clk);
    #1;
  endtask : send
  task automatic poll;
    serialPoll = 1'b1;
    @(posedge clk);
    #1;
    serialPoll = 1'b0;
  endtask : poll
endmodule : ser_ctrl_model
`default_nettype wire

// File: sim/testbench.sv
// Purpose: scenarios for status event reporting
// Assumes: controller model drives the command bus
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ns
`default_nettype none
module testbench
  import ser_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic nvPowerOnClear = 1'b0;
  logic errPush = 1'b0;
  logic errPop = 1'b0;
  logic [10:0] ev = 11'h000;
  logic [639:0] errPushText = 640'h0;
  logic cmdValid, serialPoll, respValid, serviceRequest, errEmpty, errFull;
  ser_cmd_type cmdCode;
  logic [15:0] cmdValue, respValue;
  logic [7:0] pollByte;
  logic [639:0] errText;
  logic pollValid, powerOnClear, errValid;
  logic respSeen = 1'b0;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] stdExp [11] = '{8'h01, 8'h04, 8'h08, 8'h08, 8'h10, 8'h20, 8'h08, 8'h08, 8'h08, 8'h00, 8'h00};
  logic [15:0] qualExp [11] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h2, 16'h200, 16'h800, 16'h1000};
  always #5 clk = ~clk;
  ser_ctrl_model ctrl_u (.clk, .cmdValid, .cmdCode, .cmdValue, .serialPoll);
  ser_status_event_reporting dut_u (.clk, .sys_rst, .cmdValid, .cmdCode, .cmdValue, .opcDone(ev[0]),
    .queryError(ev[1]), .selfTestFail(ev[2]), .calFail(ev[3]), .execError(ev[4]), .syntaxError(ev[5]),
    .overloadVolt(ev[6]), .overloadCurr(ev[7]), .overloadOhms(ev[8]), .limit_below_lower(ev[9]),
    .limit_above_upper(ev[10]), .messageAvailable(1'b0), .serialPoll, .nvPowerOnClear, .errPush,
    .errPushText, .errPop, .respValue, .respValid, .pollByte, .pollValid, .serviceRequest,
    .powerOnClear, .errText, .errValid, .errEmpty, .errFull);
  // respValid is a one-cycle pulse; keep it for the check after the idle edge
  always @(posedge clk) respSeen <= respValid;
  ////////////////////////////////////////////////////////////////////////
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic ask(input ser_cmd_type c, input logic [15:0] exp, input string what);
    ctrl_u.send(c, 16'h0000);
    check("respValid", 16'h0001, {15'h0000, respSeen});
    check(what, exp, respValue);
  endtask : ask
  // idle cycle after the pulse: the latch must outlive its cause
  task automatic pulse(input int i);
    ev[i] = 1'b1;
    step();
    ev[i] = 1'b0;
    step();
  endtask : pulse
  task automatic do_reset;
    sys_rst = 1'b1;
    repeat (10) step();
    sys_rst = 1'b0;
    step();
  endtask : do_reset
  task automatic t_events;
    ask(SER_CMD_ESRQ, 16'h0080, "power on");
    ask(SER_CMD_ESRQ, 16'h0000, "read clear");
    ctrl_u.send(SER_CMD_OPC, 16'h0000);
    for (int i = 0; i < 11; i++) begin
      pulse(i);
      ask(SER_CMD_ESRQ, {8'h00, stdExp[i]}, "std");
      ask(SER_CMD_QEVTQ, qualExp[i], "quality");
    end
    check("empty", 16'h0001, {15'h0000, errEmpty});
    $display("events done");
  endtask : t_events
  task automatic t_summary;
    ctrl_u.send(SER_CMD_NONE, 16'h00FF);
    ctrl_u.send(SER_CMD_ESE, 16'h0010);
    ctrl_u.send(SER_CMD_SRE, 16'h0028);
    ctrl_u.send(SER_CMD_QENA, 16'h1A03);
    ask(SER_CMD_ESEQ, 16'h0010, "ese");
    ask(SER_CMD_SREQ, 16'h0028, "sre");
    ask(SER_CMD_QENAQ, 16'h1A03, "qena");
    ask(SER_CMD_OPCQ, 16'h0001, "opc query");
    pulse(4);
    ask(SER_CMD_STBQ, 16'h0060, "stb");
    check("srq kept", 16'h0001, {15'h0000, serviceRequest});
    ctrl_u.poll();
    check("poll", 16'h0060, {8'h00, pollByte});
    check("pollValid", 16'h0001, {15'h0000, pollValid});
    ask(SER_CMD_STBQ, 16'h0020, "after poll");
    ask(SER_CMD_ESRQ, 16'h0010, "std");
    pulse(9);
    ask(SER_CMD_STBQ, 16'h0048, "quality sum");
    ctrl_u.send(SER_CMD_CLS, 16'h0000);
    ask(SER_CMD_STBQ, 16'h0000, "cls stb");
    ask(SER_CMD_QEVTQ, 16'h0000, "cls quality");
    ctrl_u.send(SER_CMD_PRESET, 16'h0000);
    ask(SER_CMD_QENAQ, 16'h0000, "preset");
    ctrl_u.send(SER_CMD_ESE, 16'h0000);
    ask(SER_CMD_ESEQ, 16'h0000, "ese zero");
    $display("summary done");
  endtask : t_summary
  task automatic t_queue;
    for (int i = 0; i < 21; i++) begin
      errPushText = {40{16'(i + 1)}};
      errPush = 1'b1;
      step();
      errPush = 1'b0;
      step();
    end
    check("full", 16'h0001, {15'h0000, errFull});
    for (int i = 0; i < 20; i++) begin
      errPop = 1'b1;
      step();
      errPop = 1'b0;
      check("oldest", 16'(i + 1), errText[15:0]);
      check("errValid", 16'h0001, {15'h0000, errValid});
      check("text top", 16'(i + 1), errText[639:624]);
      step();
    end
    check("drained", 16'h0001, {15'h0000, errEmpty});
    $display("queue done");
  endtask : t_queue
  task automatic t_power;
    ctrl_u.send(SER_CMD_PSC, 16'h0001);
    ask(SER_CMD_PSCQ, 16'h0001, "psc set");
    ctrl_u.send(SER_CMD_ESE, 16'h003C);
    ctrl_u.send(SER_CMD_QENA, 16'h0800);
    for (int n = 0; n < 2; n++) begin
      nvPowerOnClear = n[0];
      do_reset();
      ask(SER_CMD_PSCQ, {15'h0000, n[0]}, "psc");
      check("psc flag", {15'h0000, n[0]}, {15'h0000, powerOnClear});
      ask(SER_CMD_ESEQ, n[0] ? 16'h0000 : 16'h003C, "ese power");
      ask(SER_CMD_QENAQ, 16'h0000, "qena power");
    end
    $display("power done");
  endtask : t_power
  task automatic end_of_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    do_reset();
    t_events();
    t_summary();
    t_queue();
    t_power();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
